/* core/dcw_regs.svh */
`ifndef DCW_REGS_SVH
`define DCW_REGS_SVH
// Register byte offsets (chosen map, one aligned word each)
`define DCW_CFG_WORD_OFS 12'h000
`define DCW_DECODED_OFS 12'h004
// Field positions in the configuration word
`define DCW_WDT_PS_HI 20
`define DCW_WDT_PS_LO 16
`define DCW_CLKSEL_HI 15
`define DCW_CLKSEL_LO 14
`define DCW_RSVD_HI 13
`define DCW_RSVD_LO 11
`define DCW_CLKOUT_DIS_BIT 10
`define DCW_POSC_HI 9
`define DCW_POSC_LO 8
`define DCW_TWOSPD_BIT 7
`define DCW_SOSC_BIT 6
`define DCW_DMT_HI 5
`define DCW_DMT_LO 3
// Largest defined postscale code
`define DCW_WDT_PS_MAX 5'h14
// Value held until the word is latched: erased storage reads ones
`define DCW_CFG_RESET 32'hFFFFFFFF
`endif

/* core/dcw_pkg.sv */
package dcw_pkg;
  typedef enum logic [1:0] {
    DCW_POSC_EXT = 2'h0,
    DCW_POSC_RSVD = 2'h1,
    DCW_POSC_XTAL = 2'h2,
    DCW_POSC_OFF = 2'h3
  } dcw_posc_e;
  typedef enum {DCW_LOAD, DCW_HOLD} dcw_state_e;
endpackage

/* core/dcw_decoder.sv */
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`include "dcw_regs.svh"

// Summary of operation
// - Bits 20:16 select watchdog ratio 2^n
// - Codes above 20 act as code 20
// - Bits 15:14: fail monitor, clock switching
// - Bit 10 zero drives clock output
// - Clock output only in off or external modes
// - Bits 9:8 pick primary oscillator mode
// - Bit 7 enables two-speed start-up
// - Bit 6 enables secondary oscillator
// - Bits 5:3 give deadman window fraction
module dcw_decoder
  import dcw_pkg::*;
(
  input wire logic pclk, // 50 MHz bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic [31:0] nvm_cfg_word, // Stored configuration word
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data, ignored
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic cfg_valid, // Settings are latched
  output logic [4:0] watchdog_postscale_select, // Effective code 0..20
  output logic [20:0] wdt_ratio_onehot, // One-hot 2^n ratio
  output logic clock_fail_monitor_en, // Fail-safe monitor
  output logic clock_switch_en, // Run-time switching
  output logic system_clock_output_en, // Clock out on osc pin
  output logic [1:0] primary_oscillator_mode, // Raw mode field
  output logic high_speed_crystal_mode, // Crystal mode chosen
  output logic external_clock_input_mode, // External clock chosen
  output logic primary_osc_disable, // Primary oscillator off
  output logic primary_osc_mode_rsvd, // Reserved code programmed
  output logic two_speed_startup_enable, // Internal-external switch
  output logic secondary_oscillator_enable, // Low-freq oscillator on
  output logic [2:0] deadman_window_interval, // Raw window code
  output logic [7:0] deadman_window_num, // Window numerator
  output logic [7:0] deadman_window_den // Window denominator
);

  // Every check samples on the bus clock and sleeps through reset
  default clocking dcw_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Capture state
  dcw_state_e state_r, state_nxt;
  logic [31:0] cfg_r, cfg_nxt;
  logic [31:0] dec_w;
  logic [4:0] ps_raw;
  logic [2:0] dmt_code;
  logic [1:0] posc;

  // Load once after reset release, then hold; storage may not be
  // valid during reset itself, and a port cannot feed an async reset
  always_comb begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    if (state_r == DCW_LOAD) begin
      cfg_nxt = nvm_cfg_word;
      state_nxt = DCW_HOLD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= DCW_LOAD;
      cfg_r <= `DCW_CFG_RESET;
    end else begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode, all from the held word
  assign ps_raw = cfg_r[`DCW_WDT_PS_HI:`DCW_WDT_PS_LO];
  assign posc = cfg_r[`DCW_POSC_HI:`DCW_POSC_LO];
  assign dmt_code = cfg_r[`DCW_DMT_HI:`DCW_DMT_LO];

  // Undefined codes fold onto the largest ratio
  always_comb begin
    watchdog_postscale_select = ps_raw;
    if (ps_raw > `DCW_WDT_PS_MAX) begin
      watchdog_postscale_select = `DCW_WDT_PS_MAX;
    end
  end

  // One bit per ratio, n from 0 to 20
  genvar gi;
  generate
    for (gi = 0; gi < 21; gi++) begin : g_ratio
      assign wdt_ratio_onehot[gi] =
        (watchdog_postscale_select == 5'(gi));
    end
  endgenerate

  assign clock_fail_monitor_en = cfg_r[`DCW_CLKSEL_HI];
  assign clock_switch_en = cfg_r[`DCW_CLKSEL_LO];
  // Clock out needs bit low and the primary mode off or external (not crystal or reserved)
  assign system_clock_output_en = !cfg_r[`DCW_CLKOUT_DIS_BIT]
    && (posc == DCW_POSC_OFF || posc == DCW_POSC_EXT);
  assign primary_oscillator_mode = posc;
  assign high_speed_crystal_mode = (posc == DCW_POSC_XTAL);
  assign external_clock_input_mode = (posc == DCW_POSC_EXT);
  assign primary_osc_disable = (posc == DCW_POSC_OFF);
  assign primary_osc_mode_rsvd = (posc == DCW_POSC_RSVD);
  assign two_speed_startup_enable = cfg_r[`DCW_TWOSPD_BIT];
  assign secondary_oscillator_enable = cfg_r[`DCW_SOSC_BIT];
  assign deadman_window_interval = dmt_code;

  // Window (2^n-1)/2^n; code zero gives 0/1
  always_comb begin
    deadman_window_den = 8'h01 << dmt_code;
    deadman_window_num = deadman_window_den - 8'h01;
  end

  // Bits 13:11 are not checked; a programmer leaving zeros there
  // changes nothing here, which is shown in the decoded view
  assign dec_w = {cfg_valid, 10'h000, watchdog_postscale_select,
    clock_fail_monitor_en, clock_switch_en,
    cfg_r[`DCW_RSVD_HI:`DCW_RSVD_LO],
    system_clock_output_en, posc, two_speed_startup_enable,
    secondary_oscillator_enable, dmt_code, 3'h0};

  assign cfg_valid = (state_r == DCW_HOLD);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait, read-only; writes and unmapped get error
  logic [31:0] rdata_nxt;
  logic err_nxt;

  always_comb begin
    rdata_nxt = 32'h00000000;
    err_nxt = 1'b0;
    if (psel && !penable) begin
      if (pwrite) begin
        err_nxt = 1'b1;
      end else if (paddr == `DCW_CFG_WORD_OFS) begin
        rdata_nxt = cfg_r;
      end else if (paddr == `DCW_DECODED_OFS) begin
        rdata_nxt = dec_w;
      end else begin
        err_nxt = 1'b1;
      end
    end else begin
      rdata_nxt = prdata;
      err_nxt = pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata <= rdata_nxt;
      pslverr <= err_nxt;
    end
  end

  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Word must not move once latched; a change would retune the clocks
  a_word_held: assert property (cfg_valid |=>
    $stable(cfg_r) && cfg_valid)
    else $error("config word changed after latch");
  // Load edge may trail the release edge by one, reset being async
  a_load_once: assert property (!cfg_valid |-> ##[1:2]
    cfg_valid && cfg_r == $past(nvm_cfg_word))
    else $error("config word not latched");
  a_ps_clamp: assert property (ps_raw > 5'h14 |->
    watchdog_postscale_select == 5'h14)
    else $error("postscale not clamped");
  a_ps_pass: assert property (ps_raw <= 5'h14 |->
    wdt_ratio_onehot == (21'h1 << ps_raw))
    else $error("postscale ratio wrong");
  a_clksel_bits: assert property (
    {clock_fail_monitor_en, clock_switch_en} == cfg_r[15:14])
    else $error("clock switch decode wrong");
  a_clkout_gate: assert property (system_clock_output_en |->
    !cfg_r[10] && posc != 2'h2 && posc != 2'h1)
    else $error("clock out in crystal mode");
  a_clkout_on: assert property (!cfg_r[10]
    && (posc == 2'h0 || posc == 2'h3) |-> system_clock_output_en)
    else $error("clock out missing");
  a_posc_decode: assert property (
    $onehot({high_speed_crystal_mode, external_clock_input_mode,
    primary_osc_disable, primary_osc_mode_rsvd})
    && high_speed_crystal_mode == (cfg_r[9:8] == 2'h2)
    && primary_osc_disable == (cfg_r[9:8] == 2'h3))
    else $error("oscillator mode decode wrong");
  a_startup_sosc: assert property (
    two_speed_startup_enable == cfg_r[7]
    && secondary_oscillator_enable == cfg_r[6])
    else $error("start-up or secondary decode wrong");
  a_dmt_window: assert property (
    deadman_window_den == (8'h01 << cfg_r[5:3])
    && deadman_window_num + 8'h01 == deadman_window_den)
    else $error("deadman window wrong");
  a_write_err: assert property (psel && !penable && pwrite |=>
    pslverr)
    else $error("write not refused");
  a_raw_read: assert property (psel && !penable && !pwrite
    && cfg_valid && paddr == `DCW_CFG_WORD_OFS |=> prdata == cfg_r
    && !pslverr)
    else $error("raw word read wrong");
  a_bad_addr: assert property (psel && !penable && !pwrite
    && paddr != `DCW_CFG_WORD_OFS && paddr != `DCW_DECODED_OFS
    |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped read not refused");

  // Main scenarios worth seeing at least once
  c_clamp: cover property (ps_raw > 5'h14);
  c_clkout: cover property (system_clock_output_en);
  c_read: cover property (psel && penable && !pwrite && !pslverr);
  c_dmt7: cover property (dmt_code == 3'h7);
  c_load: cover property (!cfg_valid ##1 cfg_valid);

endmodule

/* sim/dcw_nvm_model.sv */
`timescale 1ns/1ps
// Storage as left by the programmer; erased cells are not modelled
module dcw_nvm_model (
  input wire logic [31:0] prog_word, // Word the programmer burns
  output logic [31:0] nvm_word // Word the device reads back
);
  // Reserved field always burned as ones, whatever the request
  always_comb begin
    nvm_word = prog_word;
    nvm_word[13:11] = 3'h7;
  end
endmodule

/* sim/device_config_word1_decoder_tb.sv */
`timescale 1ns/1ps
module device_config_word1_decoder_tb;
  typedef struct {logic [31:0] w; logic [4:0] ps; logic ck;} dcw_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, vld, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prog, nvm, rd;
  logic [20:0] oh;
  logic [4:0] ps;
  logic [2:0] dmt;
  logic [1:0] md;
  logic [7:0] num, den;
  logic mon, sw, ck, xt, ex, off, rs, ie, so;
  int n_fail, checks_done;
  // Word, expected effective postscale, expected clock-out enable
  dcw_row_s rows [4] = '{'{32'h0, 5'h00, 1'b1},
    '{32'h00140400, 5'h14, 1'b0}, '{32'h001F0300, 5'h14, 1'b1},
    '{32'h0015C2F8, 5'h14, 1'b0}};

  dcw_nvm_model nvm_i (.prog_word(prog), .nvm_word(nvm));
  dcw_decoder dut (.pclk(pclk), .presetn(presetn), .nvm_cfg_word(nvm),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_valid(vld), .watchdog_postscale_select(ps), .wdt_ratio_onehot(oh),
    .clock_fail_monitor_en(mon), .clock_switch_en(sw),
    .system_clock_output_en(ck), .primary_oscillator_mode(md),
    .high_speed_crystal_mode(xt), .external_clock_input_mode(ex),
    .primary_osc_disable(off), .primary_osc_mode_rsvd(rs),
    .two_speed_startup_enable(ie), .secondary_oscillator_enable(so),
    .deadman_window_interval(dmt), .deadman_window_num(num),
    .deadman_window_den(den));

  ////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Word is only taken at reset release, so every case reboots
  task automatic boot(logic [31:0] w);
    prog <= w;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(logic [11:0] a, logic wr);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= {20'h5A5A5, a};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk_all(logic [31:0] w, logic [4:0] eps, logic eck);
    logic [1:0] m = w[9:8];
    logic [7:0] d = 8'h1 << w[5:3];
    chk("ps", ps, eps);
    chk("ratio", oh, 21'h1 << eps);
    chk("monitor", mon, w[15]);
    chk("switch", sw, w[14]);
    chk("clk_out", ck, eck);
    chk("mode", md, m);
    chk("flags", {xt, ex, off, rs},
      {m == 2'h2, m == 2'h0, m == 2'h3, m == 2'h1});
    chk("two_speed", ie, w[7]);
    chk("sosc", so, w[6]);
    chk("window", {dmt, num, den}, {w[5:3], d - 8'h1, d});
    apb(12'h000, 1'b0);
    chk("raw", rd, w | 32'h00003800);
    chk("rd_err", er, 1'b0);
    apb(12'h004, 1'b0);
    chk("view", rd,
      {1'b1, 10'h0, eps, w[15:14], 3'h7, eck, w[9:3], 3'h0});
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Table rows, then every postscale and window code, then hazards
  initial begin
    logic [4:0] c;
    logic [31:0] word;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    prog = 32'h0;
    repeat (4) @(posedge pclk);
    chk("rst_ready", pready, 1'b1);
    chk("rst_valid", vld, 1'b0);
    chk("rst_ps", ps, 5'h14);
    foreach (rows[i]) begin
      boot(rows[i].w);
      chk_all(rows[i].w, rows[i].ps, rows[i].ck);
    end
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      word = {11'h0, c, c[4:3], 3'h0, c[3], c[1:0], c[0], c[1], c[2:0], 3'h0};
      boot(word);
      chk_all(word, (c > 5'h14) ? 5'h14 : c, !c[3] && c[1:0] != 2'h1
        && c[1:0] != 2'h2);
    end
    // Storage changes and writes after the latch must not leak through
    boot(32'h0);
    prog <= 32'hFFFFFFFF;
    apb(12'h000, 1'b1);
    chk("wr_err", er, 1'b1);
    apb(12'h000, 1'b0);
    chk("held", rd, 32'h00003800);
    chk("held_ps", ps, 5'h00);
    apb(12'h008, 1'b0);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_data", rd, 32'h0);
    close_out();
  end

  // Hang guard, well beyond the roughly 450 cycles needed
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    close_out();
  end
endmodule
